// [core/aqs_sequencer.v]
// queue scan sequencer for a queued converter
// assumes host drives one-cycle strobes; trigger pins are asynchronous
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "aqs_defs.vh"

module aqs_sequencer #(
  parameter QDEPTH = 16,
  parameter QW = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_byte,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // pins
  input wire trig1_pin,
  input wire trig2_pin,
  // analog front end
  output reg [15:0] mux_sel,
  output reg [2:0] int_sel,
  output reg sample_en,
  input wire [9:0] adc_data,
  // interrupt
  output wire irq
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  reg [1:0] t1_sync_reg;
  reg [1:0] t2_sync_reg;
  reg t1_last_reg;
  reg t2_last_reg;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t1_sync_reg <= 2'h0;
      t2_sync_reg <= 2'h0;
      t1_last_reg <= 1'b0;
      t2_last_reg <= 1'b0;
    end else begin
      t1_sync_reg <= {t1_sync_reg[0], trig1_pin};
      t2_sync_reg <= {t2_sync_reg[0], trig2_pin};
      t1_last_reg <= t1_sync_reg[1];
      t2_last_reg <= t2_sync_reg[1];
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg [15:0] ctrl_reg;
  reg [15:0] qend_reg;
  reg [15:0] cptr_reg;
  reg [`AQS_ST_W-1:0] stat_reg;
  reg [`AQS_ST_W-1:0] ien_reg;
  reg [15:0] res_reg;
  reg [15:0] cmd_mem [0:QDEPTH-1];

  wire [2:0] idx = reg_addr[3:1];
  wire odd = reg_addr[0];
  wire [1:0] m1 = ctrl_reg[`AQS_CTRL_M1];
  wire [1:0] m2 = (ctrl_reg[`AQS_CTRL_M2] == `AQS_MODE_GATE) ? `AQS_MODE_OFF :
                  ctrl_reg[`AQS_CTRL_M2];

  // byte lane merge: even byte -> upper, odd byte -> lower
  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input b;
    input o;
    begin
      if (!b)
        merge = wd;
      else if (!o)
        merge = {wd[7:0], old[7:0]};
      else
        merge = {old[15:8], wd[7:0]};
    end
  endfunction

  wire [15:0] cmd_cur = cmd_mem[cptr_reg[QW-1:0]];

  // read data: always full location
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (idx)
        `AQS_IDX_CTRL: reg_rdata <= ctrl_reg;
        `AQS_IDX_STAT: reg_rdata <= {{(16-`AQS_ST_W){1'b0}}, stat_reg};
        `AQS_IDX_IEN: reg_rdata <= {{(16-`AQS_ST_W){1'b0}}, ien_reg};
        `AQS_IDX_QEND: reg_rdata <= qend_reg;
        `AQS_IDX_RES: reg_rdata <= res_reg;
        `AQS_IDX_CMD: reg_rdata <= cmd_cur;
        `AQS_IDX_CPTR: reg_rdata <= cptr_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  localparam S_IDLE = 2'h0;
  localparam S_CONV = 2'h1;
  localparam S_PAUSE = 2'h2;

  reg [1:0] st1_reg;
  reg [1:0] st2_reg;
  reg [QW-1:0] pos1_reg;
  reg [QW-1:0] pos2_reg;
  reg act2_reg;
  reg [7:0] qdiv_reg;
  reg [7:0] qcnt_reg;
  reg [7:0] conv_len_reg;
  reg [15:0] cw_reg;

  wire [QW-1:0] q1_end = qend_reg[QW-1:0];
  wire [QW-1:0] q2_end = qend_reg[QW+7:8];
  // queue 2 starts right after the last word of queue 1
  wire [QW-1:0] q2_start = q1_end + {{(QW-1){1'b0}}, 1'b1};
  wire [15:0] nxt_cw = cmd_mem[(st1_reg == S_CONV) ? pos1_reg : pos2_reg];
  wire [1:0] nxt_ist = nxt_cw[`AQS_CW_IST];

  wire t1_lvl = t1_sync_reg[1];
  wire t1_rise = t1_lvl & ~t1_last_reg;
  wire t1_fall = ~t1_lvl & t1_last_reg;
  wire t2_rise = t2_sync_reg[1] & ~t2_last_reg;
  wire t2_fall = ~t2_sync_reg[1] & t2_last_reg;
  wire trig1 = (m1 == `AQS_MODE_TRIG) &
               (ctrl_reg[`AQS_CTRL_POL1] ? t1_fall : t1_rise);
  wire trig2 = (m2 == `AQS_MODE_TRIG) &
               (ctrl_reg[`AQS_CTRL_POL2] ? t2_fall : t2_rise);
  wire gate1 = (m1 == `AQS_MODE_GATE) & t1_lvl;
  wire gate_open = (m1 == `AQS_MODE_GATE) & t1_rise;

  wire qtick = (qdiv_reg == 8'h00);
  wire conv_done = (st1_reg == S_CONV || st2_reg == S_CONV) & qtick &
                   (qcnt_reg == conv_len_reg - 8'h01);

  reg [`AQS_ST_W-1:0] ev;
  always @* begin
    ev = {`AQS_ST_W{1'b0}};
    if (trig1 && st1_reg == S_CONV)
      ev[`AQS_ST_TOR1] = 1'b1;
    if (trig2 && (st2_reg == S_CONV || (act2_reg && st1_reg == S_CONV)))
      ev[`AQS_ST_TOR2] = 1'b1;
    if (conv_done && !act2_reg) begin
      if (pos1_reg == q1_end || cw_reg[`AQS_CW_EOQ]) begin
        if (m1 == `AQS_MODE_GATE && stat_reg[`AQS_ST_CF1])
          ev[`AQS_ST_TOR1] = 1'b1;
        else
          ev[`AQS_ST_CF1] = 1'b1;
      end else if (cw_reg[`AQS_CW_PAUSE] && m1 == `AQS_MODE_TRIG) begin
        ev[`AQS_ST_PF1] = 1'b1;
      end
    end
    if (conv_done && act2_reg) begin
      if (pos2_reg == q2_end || cw_reg[`AQS_CW_EOQ])
        ev[`AQS_ST_CF2] = 1'b1;
      else if (cw_reg[`AQS_CW_PAUSE])
        ev[`AQS_ST_PF2] = 1'b1;
    end
  end

  wire clr_wr = reg_wr && idx == `AQS_IDX_CLR;
  wire [15:0] ien_wr = merge({{(16-`AQS_ST_W){1'b0}}, ien_reg}, reg_wdata, reg_byte, odd);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= 16'h0000;
      qend_reg <= 16'h0000;
      cptr_reg <= 16'h0000;
      stat_reg <= {`AQS_ST_W{1'b0}};
      ien_reg <= {`AQS_ST_W{1'b0}};
    end else begin
      if (reg_wr) begin
        case (idx)
          `AQS_IDX_CTRL: ctrl_reg <= merge(ctrl_reg, reg_wdata, reg_byte, odd);
          `AQS_IDX_IEN: ien_reg <= ien_wr[`AQS_ST_W-1:0];
          `AQS_IDX_QEND: qend_reg <= merge(qend_reg, reg_wdata, reg_byte, odd);
          `AQS_IDX_CPTR: cptr_reg <= merge(cptr_reg, reg_wdata, reg_byte, odd);
          default: ;
        endcase
      end
      // set wins over clear
      stat_reg <= (stat_reg & ~(clr_wr ? reg_wdata[`AQS_ST_W-1:0] :
                   {`AQS_ST_W{1'b0}})) | ev;
    end
  end

  integer i;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < QDEPTH; i = i + 1)
        cmd_mem[i] <= 16'h0000;
    end else if (reg_wr && idx == `AQS_IDX_CMD) begin
      cmd_mem[cptr_reg[QW-1:0]] <= merge(cmd_cur, reg_wdata, reg_byte, odd);
    end
  end

  assign irq = |(stat_reg & ien_reg);

  // converter clock divider and sequencing
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st1_reg <= S_IDLE;
      st2_reg <= S_IDLE;
      pos1_reg <= {QW{1'b0}};
      pos2_reg <= {QW{1'b0}};
      act2_reg <= 1'b0;
      qdiv_reg <= 8'h00;
      qcnt_reg <= 8'h00;
      conv_len_reg <= `AQS_CONV_MIN;
      cw_reg <= 16'h0000;
      res_reg <= 16'h0000;
      mux_sel <= 16'h0000;
      int_sel <= 3'h0;
      sample_en <= 1'b0;
    end else begin
      qdiv_reg <= qtick ? ctrl_reg[`AQS_CTRL_CDIV] : qdiv_reg - 8'h01;
      if ((st1_reg == S_CONV || st2_reg == S_CONV) && qtick)
        qcnt_reg <= conv_done ? 8'h00 : qcnt_reg + 8'h01;
      sample_en <= 1'b0;
      // queue 1 control
      if (m1 == `AQS_MODE_OFF || (m1 == `AQS_MODE_GATE && !gate1)) begin
        if (!act2_reg)
          st1_reg <= S_IDLE;
      end else if (gate_open) begin
        st1_reg <= S_CONV;
        pos1_reg <= {QW{1'b0}};
        qcnt_reg <= 8'h00;
      end else if (trig1 && st1_reg != S_CONV) begin
        st1_reg <= S_CONV;
        if (st1_reg == S_IDLE)
          pos1_reg <= {QW{1'b0}};
      end
      if (trig2 && st2_reg != S_CONV) begin
        st2_reg <= S_CONV;
        if (st2_reg == S_IDLE)
          pos2_reg <= q2_start;
      end
      if (m2 == `AQS_MODE_OFF)
        st2_reg <= S_IDLE;
      // load next word when not converting (queue 1 has priority)
      if (qtick && qcnt_reg == 8'h00) begin
        act2_reg <= (st1_reg != S_CONV);
        cw_reg <= nxt_cw;
        // 14 clocks at the shortest sample, 20 at the longest
        conv_len_reg <= `AQS_CONV_MIN + {5'h00, nxt_ist, 1'b0};
      end
      // channel routing
      if (qtick && qcnt_reg == 8'h01) begin
        sample_en <= 1'b1;
        mux_sel <= 16'h0000;
        int_sel <= 3'h0;
        case (cw_reg[`AQS_CW_CHAN])
          `AQS_CH_REFH: int_sel <= 3'h1;
          `AQS_CH_REFL: int_sel <= 3'h2;
          `AQS_CH_MID: int_sel <= 3'h4;
          default: mux_sel <= 16'h0001 << cw_reg[3:0];
        endcase
      end
      if (conv_done) begin
        res_reg <= {6'h00, adc_data};
        if (!act2_reg) begin
          if (pos1_reg == q1_end || cw_reg[`AQS_CW_EOQ]) begin
            pos1_reg <= {QW{1'b0}};
            if (m1 != `AQS_MODE_GATE)
              st1_reg <= S_IDLE;
          end else begin
            pos1_reg <= pos1_reg + {{(QW-1){1'b0}}, 1'b1};
            if (cw_reg[`AQS_CW_PAUSE] && m1 == `AQS_MODE_TRIG)
              st1_reg <= S_PAUSE;
          end
        end else begin
          if (pos2_reg == q2_end || cw_reg[`AQS_CW_EOQ]) begin
            pos2_reg <= q2_start;
            st2_reg <= S_IDLE;
          end else begin
            pos2_reg <= pos2_reg + {{(QW-1){1'b0}}, 1'b1};
            if (cw_reg[`AQS_CW_PAUSE])
              st2_reg <= S_PAUSE;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// [core/aqs_defs.vh]
// constants for the queued converter scan sequencer
// assumes a single ref_clk domain and the plain strobe register port
//
// Overview of operation
// - trigger edge, selectable polarity, starts queue
// - run words to end; restart next edge
// - trigger mode: pause halts until next trigger
// - gated mode exists on queue 1 only
// - gate fixed: high opens, low closes
// - run while open; reopen restarts at start
// - gated mode ignores pause bit entirely
// - end while open: completion flag, wrap
// - end again with flag set: overrun, wrap
// - queue 2 trigger while suspended sets overrun
// - even byte write changes upper byte only, except clear, which takes the low data bits
// - odd byte write changes lower byte only
// - word access at even address, one cycle
// - odd word access writes whole location, one cycle
// - conversion 14 clocks; 20 with 8 sample
// - channel field picks one of 16 inputs
// - three internal reference channels also selectable
`ifndef AQS_DEFS_VH
`define AQS_DEFS_VH

// register indices (16-bit locations, byte address = 2 x index)
`define AQS_IDX_CTRL 3'h0
`define AQS_IDX_STAT 3'h1
`define AQS_IDX_CLR 3'h2
`define AQS_IDX_IEN 3'h3
`define AQS_IDX_QEND 3'h4
`define AQS_IDX_RES 3'h5
`define AQS_IDX_CMD 3'h6
`define AQS_IDX_CPTR 3'h7

// control fields
`define AQS_CTRL_M1 1:0
`define AQS_CTRL_M2 3:2
`define AQS_CTRL_POL1 4
`define AQS_CTRL_POL2 5
`define AQS_CTRL_CDIV 15:8

// queue modes
`define AQS_MODE_OFF 2'h0
`define AQS_MODE_TRIG 2'h1
`define AQS_MODE_GATE 2'h2

// status bits
`define AQS_ST_CF1 0
`define AQS_ST_PF1 1
`define AQS_ST_TOR1 2
`define AQS_ST_CF2 3
`define AQS_ST_PF2 4
`define AQS_ST_TOR2 5
`define AQS_ST_W 6

// command word fields
`define AQS_CW_PAUSE 15
`define AQS_CW_EOQ 14
`define AQS_CW_IST 9:8
`define AQS_CW_CHAN 5:0

// conversion timing in converter clocks
`define AQS_CONV_BASE 8'h0C
`define AQS_CONV_MIN 8'h0E
`define AQS_CONV_MAX 8'h14

// internal channel codes
`define AQS_CH_REFH 6'h3C
`define AQS_CH_REFL 6'h3D
`define AQS_CH_MID 6'h3E

`endif

// [tb/aqs_front_model.sv]
// front end model: turns the selected channel into a result code
// assumes one-hot selects qualified by sample_en
`timescale 1ns/1ps
`default_nettype none
module aqs_front_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // selects from the sequencer
  input wire logic [15:0] mux_sel,
  input wire logic [2:0] int_sel,
  input wire logic sample_en,
  // result
  output logic [9:0] adc_data
);
  integer i;
  reg [5:0] code;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      adc_data <= 10'h000;
    end else if (sample_en) begin
      code = 6'h3F;
      for (i = 0; i < 16; i = i + 1) if (mux_sel[i]) code = i[5:0];
      if (int_sel[0]) code = 6'h3C;
      if (int_sel[1]) code = 6'h3D;
      if (int_sel[2]) code = 6'h3E;
      adc_data <= {4'h5, code};
    end
  end
endmodule
`default_nettype wire

// [tb/aqs_monitor.sv]
// checker on the sequencer ports
// assumes one ref_clk domain, rstn active low
`timescale 1ns/1ps
`default_nettype none
module aqs_monitor #(parameter QDEPTH = 16, parameter QW = 4) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_byte,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // pins, front end, interrupt
  input wire logic trig1_pin,
  input wire logic trig2_pin,
  input wire logic [15:0] mux_sel,
  input wire logic [2:0] int_sel,
  input wire logic sample_en,
  input wire logic [9:0] adc_data,
  input wire logic irq
);
  localparam [15:0] QM = ((16'h0001 << QW) - 16'h0001) * 16'h0101;
  reg [4:0] gap_reg;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) gap_reg <= 5'h1F;
    else if (sample_en) gap_reg <= 5'h00;
    else if (gap_reg != 5'h1F) gap_reg <= gap_reg + 5'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr_rd(a, b);
    reg_wr && reg_byte == b && reg_addr == a ##1 reg_rd && reg_addr == 4'h8;
  endsequence
  property p_word;
    s_wr_rd(4'h8, 1'b0) |=> (reg_rdata & QM) == ($past(reg_wdata, 2) & QM);
  endproperty
  property p_even;
    s_wr_rd(4'h8, 1'b1) |=> (reg_rdata[15:8] & QM[7:0]) == ($past(reg_wdata[7:0], 2) & QM[7:0]);
  endproperty
  property p_odd;
    s_wr_rd(4'h9, 1'b1) |=> (reg_rdata[7:0] & QM[7:0]) == ($past(reg_wdata[7:0], 2) & QM[7:0]);
  endproperty
  property p_onehot;
    sample_en |-> $onehot({mux_sel, int_sel});
  endproperty
  property p_gap;
    sample_en |-> gap_reg >= 5'h0D;
  endproperty
  property p_pulse;
    sample_en |=> !sample_en [*8];
  endproperty
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  property p_irq_off;
    reg_wr && !reg_byte && reg_addr == 4'h6 && reg_wdata == 16'h0000 |=> !irq;
  endproperty
  a_word: assert property (p_word) else $error("word write not read back");
  a_even: assert property (p_even) else $error("even byte write wrong");
  a_odd: assert property (p_odd) else $error("odd byte write wrong");
  a_onehot: assert property (p_onehot) else $error("channel select not one-hot");
  a_gap: assert property (p_gap) else $error("conversion too short");
  a_pulse: assert property (p_pulse) else $error("sample start repeats");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_irq_off: assert property (p_irq_off) else $error("irq high with all masked");
endmodule
bind aqs_sequencer aqs_monitor #(.QDEPTH(QDEPTH), .QW(QW)) u_mon (.ref_clk(ref_clk),
  .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_byte(reg_byte),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig1_pin(trig1_pin),
  .trig2_pin(trig2_pin), .mux_sel(mux_sel), .int_sel(int_sel), .sample_en(sample_en),
  .adc_data(adc_data), .irq(irq));
`default_nettype wire

// [tb/tb_top.sv]
// bench for the scan sequencer
// assumes 20 MHz ref_clk, front end model on the far side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_byte = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg trig1_pin = 1'b0;
  reg trig2_pin = 1'b0;
  wire [15:0] reg_rdata;
  wire [15:0] mux_sel;
  wire [2:0] int_sel;
  wire sample_en;
  wire [9:0] adc_data;
  wire irq;
  integer err_count = 0;
  integer cmp_count = 0;
  reg [15:0] v;
  always #25 ref_clk = ~ref_clk;
  aqs_sequencer dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_byte(reg_byte), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig1_pin(trig1_pin), .trig2_pin(trig2_pin),
    .mux_sel(mux_sel), .int_sel(int_sel), .sample_en(sample_en), .adc_data(adc_data),
    .irq(irq));
  aqs_front_model u_front (.ref_clk(ref_clk), .rstn(rstn), .mux_sel(mux_sel),
    .int_sel(int_sel), .sample_en(sample_en), .adc_data(adc_data));
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input [15:0] s, input [15:0] e, input [63:0] nm);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("[ERR] %0s exp %h got %h", nm, e, s);
    end
  endtask
  // strobe stays up so writes may follow back to back
  task wr(input [3:0] a, input [15:0] d, input b);
    reg_addr <= a;
    reg_wdata <= d;
    reg_byte <= b;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input [3:0] a);
    reg_addr <= a;
    reg_byte <= 1'b0;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task idle(input integer n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task ld(input [3:0] i, input [15:0] w);
    wr(4'hE, {12'h000, i}, 1'b0);
    wr(4'hC, w, 1'b0);
  endtask
  task pin(input integer n, input l);
    if (n == 1) trig1_pin <= l;
    else trig2_pin <= l;
    repeat (4) @(posedge ref_clk);
  endtask
  task wirq;
    integer i;
    for (i = 0; i < 4000 && irq !== 1'b1; i = i + 1) @(negedge ref_clk);
    if (irq !== 1'b1) begin
      err_count = err_count + 1;
      $display("[ERR] irq exp 1 got %b", irq);
      wrap_up;
    end
    @(posedge ref_clk);
  endtask
  task t_regs;
    rd(4'h0); chk(v, 16'h0000, "ctrl");
    wr(4'h8, 16'h0305, 1'b0); rd(4'h8); chk(v, 16'h0305, "qend");
    wr(4'h8, 16'h0002, 1'b1); rd(4'h8); chk(v, 16'h0205, "qend");
    wr(4'h9, 16'h0001, 1'b1); rd(4'h8); chk(v, 16'h0201, "qend");
    wr(4'h7, 16'h0001, 1'b1); wr(4'h8, 16'h0003, 1'b1);
    rd(4'h6); chk(v, 16'h0001, "ien");
    rd(4'h8); chk(v, 16'h0301, "qend");
    wr(4'h2, 16'h003F, 1'b0); rd(4'h2); chk(v, 16'h0000, "status");
  endtask
  task t_trig;
    ld(4'h0, 16'h0003); ld(4'h1, 16'h403C); ld(4'h2, 16'h8005); ld(4'h3, 16'h403D);
    wr(4'h0, 16'h0001, 1'b0); idle(2);
    pin(1, 1'b1); pin(1, 1'b0); wirq;
    rd(4'h2); chk(v & 16'h003F, 16'h0001, "status");
    rd(4'hA); chk(v & 16'h03FF, 16'h017C, "result");
    wr(4'h4, 16'h003F, 1'b0); wr(4'h0, 16'h0011, 1'b0); idle(1);
    pin(1, 1'b1); idle(100); chk({15'h0000, irq}, 16'h0000, "irq");
    pin(1, 1'b0); wirq;
    rd(4'h2); chk(v & 16'h003F, 16'h0001, "status");
    wr(4'h6, 16'h0000, 1'b0); idle(1); chk({15'h0000, irq}, 16'h0000, "irq");
    wr(4'h6, 16'h0001, 1'b0); idle(1); chk({15'h0000, irq}, 16'h0001, "irq");
  endtask
  task t_pause;
    wr(4'h4, 16'h003F, 1'b0); wr(4'h6, 16'h0018, 1'b0); wr(4'h0, 16'h0004, 1'b0); idle(2);
    pin(2, 1'b1); pin(2, 1'b0); wirq;
    rd(4'h2); chk(v & 16'h003F, 16'h0010, "status");
    wr(4'h4, 16'h003F, 1'b0); idle(100); chk({15'h0000, irq}, 16'h0000, "irq");
    pin(2, 1'b1); pin(2, 1'b0); wirq;
    rd(4'h2); chk(v & 16'h003F, 16'h0008, "status");
    rd(4'hA); chk(v & 16'h03FF, 16'h017D, "result");
  endtask
  task t_gate;
    integer i;
    wr(4'h4, 16'h003F, 1'b0); ld(4'h0, 16'h8003);
    wr(4'h6, 16'h0004, 1'b0); wr(4'h0, 16'h0016, 1'b0); idle(2);
    pin(1, 1'b1); pin(2, 1'b1); pin(2, 1'b0); pin(2, 1'b1); pin(2, 1'b0);
    wirq; pin(1, 1'b0); idle(100);
    rd(4'h2); chk(v & 16'h0027, 16'h0025, "status");
    wr(4'h4, 16'h003F, 1'b0); idle(1);
    trig1_pin <= 1'b1;
    for (i = 0; i < 300 && sample_en !== 1'b1; i = i + 1) @(negedge ref_clk);
    chk({15'h0000, sample_en}, 16'h0001, "sample");
    chk(mux_sel, 16'h0008, "mux");
    @(posedge ref_clk);
    trig1_pin <= 1'b0;
    wr(4'h0, 16'h0000, 1'b0); idle(40);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_trig;
    t_pause;
    t_gate;
    wrap_up;
  end
endmodule
`default_nettype wire
